// ### progmap_pkg.sv
package progmap_pkg;

  // ---------------------------------------------------------------------
  // address space
  // ---------------------------------------------------------------------
  localparam int          PC_W         = 21;
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] HIGH_VECTOR  = 21'h000008;
  localparam logic [20:0] LOW_VECTOR   = 21'h000018;
  localparam logic [20:0] SPACE_TOP    = 21'h1FFFFF;
  localparam int          FLASH_MIN_KB = 32;
  localparam int          FLASH_MAX_KB = 128;
  localparam int          FLASH_DEF_KB = 32;
  localparam logic [20:0] CFG_AREA_LEN = 21'h000008;
  localparam logic [2:0]  CFG_BYTES    = 3'h6;

  // ---------------------------------------------------------------------
  // external bus configuration byte
  // ---------------------------------------------------------------------
  localparam int         WAIT_BIT   = 7;
  localparam int         WIDTH_BIT  = 6;
  localparam int         MODE_HI    = 5;
  localparam int         MODE_LO    = 4;
  localparam int         SHIFT_BIT  = 3;
  localparam logic [7:0] EBC_MASK   = 8'hF8;
  localparam logic [7:0] EBC_ERASED = 8'hF8;
  localparam logic [1:0] MODE_ONCHIP = 2'h3;
  localparam logic [1:0] MODE_EXT12  = 2'h2;
  localparam logic [1:0] MODE_EXT16  = 2'h1;
  localparam logic [1:0] MODE_EXT20  = 2'h0;

  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [3:0] REG_EBC     = 4'h0;
  localparam logic [3:0] REG_MEMCTL  = 4'h4;
  localparam logic [3:0] REG_STATUS  = 4'h8;
  localparam logic [3:0] REG_CFGW1   = 4'hC;
  localparam logic [7:0] MEMCTL_RST  = 8'h00;

  typedef enum logic [2:0] {
    ST_LOAD  = 3'h1,
    ST_RUN   = 3'h2,
    ST_IDLE  = 3'h4
  } boot_state_t;

  typedef struct packed {
    logic        req;
    logic [20:0] addr;
  } fetch_req_t;

  typedef struct packed {
    logic        ext_sel;
    logic        zero_fill;
    logic [19:0] ext_addr;
    logic        ext_en;
    logic        wide_data;
    logic        wait_en;
    logic [1:0]  wait_count;
  } route_t;

  typedef struct packed {
    boot_state_t state;
    logic [2:0]  cfg_idx;
    logic [7:0]  cfg1_lo;
    logic [7:0]  cfg1_hi;
    logic [7:0]  ebc;
    logic        ebc_written;
    logic [7:0]  memctl;
    logic        rdv;
    logic [31:0] rdata;
  } map_state_t;

endpackage : progmap_pkg

// ### progmap_decoder.sv
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
module progmap_decoder #(
  parameter int FLASH_KB = progmap_pkg::FLASH_DEF_KB,
  parameter bit PINS_80  = 1'b1
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // register bus (avalon-mm)
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // core program fetch side
  input  wire progmap_pkg::fetch_req_t fetch_in,
  input  wire logic                    irq_high,
  input  wire logic                    irq_low,
  output logic      [20:0]             vector_addr,
  output logic                         boot_done,
  output logic      [15:0]             fetch_data,
  output progmap_pkg::route_t          route,
  // on-chip flash read port
  output logic      [20:0]             flash_addr,
  input  wire logic [15:0]             flash_rdata,
  // external program memory
  input  wire logic [15:0]             ext_rdata
);
  import progmap_pkg::*;

  // ---------------------------------------------------------------------
  // derived map
  // ---------------------------------------------------------------------
  // size outside 32..128 is clamped so the map stays sane
  localparam int KB = (FLASH_KB < FLASH_MIN_KB) ? FLASH_MIN_KB :
                      (FLASH_KB > FLASH_MAX_KB) ? FLASH_MAX_KB : FLASH_KB;
  localparam logic [20:0] ONCHIP_SIZE = 21'(KB * 1024);
  localparam logic [20:0] CFG_BASE    = ONCHIP_SIZE - CFG_AREA_LEN;

  function automatic logic [20:0] ext_mask(input logic [1:0] m);
    unique case (m)
      MODE_EXT12: ext_mask = 21'h000FFF;
      MODE_EXT16: ext_mask = 21'h00FFFF;
      default:    ext_mask = 21'h0FFFFF;
    endcase
  endfunction : ext_mask

  map_state_t s_reg;
  map_state_t s_next;

  logic [7:0]  ebc_eff;
  logic [1:0]  mode;
  logic        onchip;
  logic [20:0] pa;
  logic        in_chip;
  logic [20:0] ext_full;
  logic        ext_hit;
  logic [7:0]  cfg_byte;

  // ---------------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------------
  always_comb begin
    ebc_eff = s_reg.ebc & EBC_MASK;
    // small packages have no external bus pins at all
    mode    = PINS_80 ? ebc_eff[MODE_HI:MODE_LO] : MODE_ONCHIP;
    onchip  = (mode == MODE_ONCHIP);
  end

  // ---------------------------------------------------------------------
  // fetch routing; independent of the data path
  // ---------------------------------------------------------------------
  always_comb begin
    pa      = fetch_in.addr;
    in_chip = (pa < ONCHIP_SIZE);
    ext_hit = fetch_in.req && !in_chip && !onchip && boot_done;
    if (ebc_eff[SHIFT_BIT]) begin
      ext_full = pa - ONCHIP_SIZE;
    end else begin
      ext_full = pa;
    end
    ext_full = ext_full & ext_mask(mode);
    route.ext_sel    = ext_hit;
    route.zero_fill  = !in_chip && onchip;
    route.ext_addr   = ext_full[19:0];
    route.ext_en     = !onchip;
    route.wide_data  = ebc_eff[WIDTH_BIT];
    route.wait_en    = !ebc_eff[WAIT_BIT];
    route.wait_count = ebc_eff[WAIT_BIT] ? 2'h0 : s_reg.memctl[5:4];
  end

  // ---------------------------------------------------------------------
  // vectors and flash address
  // ---------------------------------------------------------------------
  always_comb begin
    if (!boot_done) begin
      vector_addr = RESET_VECTOR;
    end else if (irq_high) begin
      vector_addr = HIGH_VECTOR;
    end else if (irq_low) begin
      vector_addr = LOW_VECTOR;
    end else begin
      vector_addr = RESET_VECTOR;
    end
    if (s_reg.state == ST_LOAD) begin
      // byte-wide copy, ascending: word1 low first
      flash_addr = CFG_BASE + 21'(s_reg.cfg_idx);
    end else begin
      flash_addr = pa;
    end
    cfg_byte = flash_rdata[7:0];
  end

  // data outputs registered to keep fetch timing clean
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fetch_data <= 16'h0000;
    end else if (!boot_done) begin
      fetch_data <= 16'h0000;
    end else if (in_chip) begin
      fetch_data <= flash_rdata;
    end else if (ext_hit) begin
      fetch_data <= ext_rdata;
    end else begin
      fetch_data <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------------
  // boot copy and registers
  // ---------------------------------------------------------------------
  always_comb begin
    s_next     = s_reg;
    s_next.rdv = 1'b0;
    unique case (s_reg.state)
      ST_LOAD: begin
        // only the first three words (six bytes) are loaded
        unique case (s_reg.cfg_idx)
          3'h0: s_next.cfg1_lo = cfg_byte;
          3'h1: s_next.cfg1_hi = cfg_byte;
          3'h4: s_next.ebc     = cfg_byte & EBC_MASK;
          default: ;
        endcase
        if (s_reg.cfg_idx == CFG_BYTES - 3'h1) begin
          s_next.state = ST_RUN;
        end else begin
          s_next.cfg_idx = s_reg.cfg_idx + 3'h1;
        end
      end
      ST_RUN, ST_IDLE: begin
        if (avs_write) begin
          unique case (avs_address)
            REG_EBC: begin
              if (!s_reg.ebc_written) begin
                s_next.ebc = avs_writedata[7:0] & EBC_MASK;
                s_next.ebc_written = 1'b1;
              end
            end
            REG_MEMCTL: s_next.memctl = avs_writedata[7:0];
            default: ;
          endcase
        end
        // capture once per read: a held read must not reuse old data
        if (avs_read && !s_reg.rdv) begin
          s_next.rdv = 1'b1;
          unique case (avs_address)
            REG_EBC:    s_next.rdata = {24'h000000, ebc_eff};
            REG_MEMCTL: s_next.rdata = {24'h000000, s_reg.memctl};
            REG_STATUS: s_next.rdata = {27'h0000000, s_reg.ebc_written,
                                        route.wide_data, onchip, mode};
            REG_CFGW1:  s_next.rdata = {16'h0000, s_reg.cfg1_hi,
                                        s_reg.cfg1_lo};
            default:    s_next.rdata = 32'h00000000;
          endcase
        end
        s_next.state = (avs_read && !s_reg.rdv) ? ST_IDLE : ST_RUN;
      end
      default: s_next.state = ST_LOAD;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg.state       <= ST_LOAD;
      s_reg.cfg_idx     <= 3'h0;
      s_reg.cfg1_lo     <= 8'h00;
      s_reg.cfg1_hi     <= 8'h00;
      s_reg.ebc         <= EBC_ERASED;
      s_reg.ebc_written <= 1'b0;
      s_reg.memctl      <= MEMCTL_RST;
      s_reg.rdv         <= 1'b0;
      s_reg.rdata       <= 32'h00000000;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------------
  // reads take one wait cycle; writes complete at once after boot
  always_comb begin
    boot_done       = (s_reg.state != ST_LOAD);
    avs_readdata    = s_reg.rdata;
    avs_waitrequest = !boot_done || (avs_read && !s_reg.rdv);
  end

endmodule : progmap_decoder

// ### ext_mem_model.sv
`timescale 1ns/1ns
module ext_mem_model (
  // bus from the block
  input  wire progmap_pkg::route_t route,
  // data back
  output logic [15:0]              ext_rdata
);
  import progmap_pkg::*;
  // an idle bus shows the inverted address, never a stale word
  assign ext_rdata = (route.ext_en && route.ext_sel) ?
    (route.ext_addr[15:0] ^ 16'h5A5A) : ~route.ext_addr[15:0];
endmodule : ext_mem_model

// ### progmap_decoder_props.sv
`timescale 1ns/1ns
module progmap_decoder_props #(
  parameter int FLASH_KB = progmap_pkg::FLASH_DEF_KB
) (
  // clock, reset, bus
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire logic [3:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // fetch, flash, external
  input wire progmap_pkg::fetch_req_t fetch_in,
  input wire logic                    irq_high,
  input wire logic                    irq_low,
  input wire logic [20:0]             vector_addr,
  input wire logic                    boot_done,
  input wire logic [15:0]             fetch_data,
  input wire progmap_pkg::route_t     route,
  input wire logic [20:0]             flash_addr,
  input wire logic [15:0]             flash_rdata,
  input wire logic [15:0]             ext_rdata
);
  import progmap_pkg::*;
  // ------
  // cycles since reset release, saturating
  // ------
  localparam logic [20:0] TOP = 21'(FLASH_KB * 1024);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  always_comb cnt_next = (cnt_reg == 3'h7) ? cnt_reg : cnt_reg + 3'h1;
  always_ff @(posedge sys_clk) cnt_reg <= rst_n ? cnt_next : 3'h0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_boot; boot_done == (cnt_reg >= 3'h6); endproperty
  a_boot: assert property (p_boot) else $error("boot length");
  property p_cfg; !boot_done |->
    flash_addr == TOP - CFG_AREA_LEN + 21'(cnt_reg); endproperty
  a_cfg: assert property (p_cfg) else $error("config address");
  property p_rst; !boot_done |-> vector_addr == RESET_VECTOR; endproperty
  a_rst: assert property (p_rst) else $error("reset vector");
  property p_hi; boot_done && irq_high |-> vector_addr == HIGH_VECTOR;
  endproperty
  a_hi: assert property (p_hi) else $error("high vector");
  property p_path; boot_done && fetch_in.req |->
    flash_addr == fetch_in.addr; endproperty
  a_path: assert property (p_path) else $error("fetch path");
  property p_sel; boot_done && fetch_in.req && route.ext_en |->
    route.ext_sel == (fetch_in.addr >= TOP); endproperty
  a_sel: assert property (p_sel) else $error("memory select");
  property p_zero; boot_done && fetch_in.req && !route.ext_en &&
    fetch_in.addr >= TOP |-> route.zero_fill ##1 fetch_data == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("zero fill");
  property p_rdw; boot_done && $rose(avs_read) |->
    avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_rdw: assert property (p_rdw) else $error("read wait");
endmodule : progmap_decoder_props

bind progmap_decoder progmap_decoder_props #(.FLASH_KB(FLASH_KB)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .fetch_in(fetch_in),
  .irq_high(irq_high), .irq_low(irq_low), .vector_addr(vector_addr),
  .boot_done(boot_done), .fetch_data(fetch_data), .route(route),
  .flash_addr(flash_addr), .flash_rdata(flash_rdata),
  .ext_rdata(ext_rdata));

// ### progmap_decoder_tb.sv
`timescale 1ns/1ns
module progmap_decoder_tb;
  import progmap_pkg::*;
  // ------
  // signals and models
  // ------
  localparam logic [20:0] TOP = 21'h008000;
  logic        sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0;
  logic        avs_write = 1'b0, irq_high = 1'b0, irq_low = 1'b0;
  logic        boot_done, avs_waitrequest;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [20:0] vector_addr, flash_addr;
  logic [15:0] fetch_data, flash_rdata, ext_rdata;
  fetch_req_t  fetch_in = '0;
  route_t      route;
  int          errors = 0, check_count = 0, cycles = 0;
  // flash word is its own low address byte; config byte 4 sets the bus
  assign flash_rdata = (flash_addr == TOP - 21'h4) ? 16'h0008
                                                   : {2{flash_addr[7:0]}};
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      end_of_test();
    end
  end
  progmap_decoder #(.FLASH_KB(32), .PINS_80(1'b1)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fetch_in(fetch_in),
    .irq_high(irq_high), .irq_low(irq_low), .vector_addr(vector_addr),
    .boot_done(boot_done), .fetch_data(fetch_data), .route(route),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata),
    .ext_rdata(ext_rdata));
  ext_mem_model mem (.route(route), .ext_rdata(ext_rdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // sampled at the edge, before that edge's updates land
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic fetch(input logic [20:0] a, input logic sel,
                       input logic [15:0] d);
    @(posedge sys_clk);
    fetch_in <= '{req: 1'b1, addr: a};
    @(negedge sys_clk);
    check(route.ext_sel, sel);
    @(negedge sys_clk);
    check(fetch_data, d);
    @(posedge sys_clk);
    fetch_in <= '0;
  endtask : fetch
  task automatic t_boot;
    @(negedge sys_clk);
    check(vector_addr, RESET_VECTOR);
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check(boot_done, 1'b0);
    @(negedge sys_clk);
    check(boot_done, 1'b1);
    bus(1'b0, REG_EBC, 32'h0);
    check(rd, 32'h08);
    bus(1'b0, REG_CFGW1, 32'h0);
    check(rd, 32'hF9F8);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    $display("boot test done");
  endtask : t_boot
  task automatic t_vec;
    @(posedge sys_clk);
    irq_high <= 1'b1;
    @(negedge sys_clk);
    check(vector_addr, HIGH_VECTOR);
    @(posedge sys_clk);
    irq_high <= 1'b0;
    irq_low <= 1'b1;
    @(negedge sys_clk);
    check(vector_addr, LOW_VECTOR);
    @(posedge sys_clk);
    irq_low <= 1'b0;
    $display("vector test done");
  endtask : t_vec
  task automatic t_ext;
    fetch(21'h000124, 1'b0, 16'h2424);
    fetch(TOP - 21'h2, 1'b0, 16'hFEFE);
    fetch(TOP + 21'h1000, 1'b1, 16'h4A5A);
    check({route.wait_en, route.wide_data}, 2'h2);
    bus(1'b1, REG_MEMCTL, 32'h30);
    bus(1'b0, REG_MEMCTL, 32'h0);
    check(rd, 32'h30);
    check(route.wait_count, 2'h3);
    $display("extended test done");
  endtask : t_ext
  task automatic t_write;
    bus(1'b1, REG_EBC, 32'hF7);
    bus(1'b0, REG_EBC, 32'h0);
    check(rd, 32'hF0);
    bus(1'b1, REG_EBC, 32'h08);
    bus(1'b0, REG_EBC, 32'h0);
    check(rd, 32'hF0);
    fetch(TOP + 21'h1000, 1'b0, 16'h0000);
    check({route.ext_en, route.wait_en, route.wide_data}, 3'h1);
    check(route.wait_count, 2'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h1F);
    $display("write-once test done");
  endtask : t_write
  task automatic reset_dut;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check(boot_done, 1'b0);
    check(vector_addr, RESET_VECTOR);
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    check(boot_done, 1'b1);
  endtask : reset_dut
  task automatic t_mode;
    // a reset re-arms the write-once byte, so each narrow mode gets a turn
    reset_dut();
    bus(1'b0, REG_EBC, 32'h0);
    check(rd, 32'h08);
    bus(1'b1, REG_EBC, 32'hA0);
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h12);
    fetch(TOP + 21'h1234, 1'b1, 16'h586E);
    reset_dut();
    bus(1'b1, REG_EBC, 32'h90);
    fetch(TOP + 21'h11234, 1'b1, 16'hC86E);
    $display("mode test done");
  endtask : t_mode
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_boot();
    t_vec();
    t_ext();
    t_write();
    t_mode();
    end_of_test();
  end
endmodule : progmap_decoder_tb
